// file: logic/pmt_cfg.svh
//Function
//- act as version 1.2 management target
//- generate and check the PEC byte
//- stretch SCL low while processing bytes
//- host waits for SCL really high
//- pull alert pin low on status
//- all conditions alert after reset
//- masked conditions never pull alert low
//- default: enable pin alone controls conversion
//- on/off config reshapes enable and operation
//- current read returns filtered value
//- voltage reads return measured vout, vin
//- temperature two returns die temperature
//- frequency read returns switching kHz
//- linear format, vout per vout mode
//- full compliance up to 100 kHz
//- 400 kHz only with data setup kept
//- total stretching per transaction within 25 ms
//- warnings flag only, faults also respond
//- 7-bit address caught once after reset
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH
// timing figures
`define PMT_CLK_HZ          40_000_000
`define PMT_SCL_HZ          100_000
`define PMT_SU_DAT_NS       150
`define PMT_STRETCH_MS      25
`define PMT_TIMEOUT_MS      25
`define PMT_STRETCH_CYC     8'h10
`define PMT_TMR_W           21
// command codes
`define PMT_CMD_OPER        8'h01
`define PMT_CMD_ONOFF       8'h02
`define PMT_CMD_CLEAR       8'h03
`define PMT_CMD_MASK        8'h1B
`define PMT_CMD_VOUT_MODE   8'h20
`define PMT_CMD_STATUS      8'h78
`define PMT_CMD_VIN         8'h88
`define PMT_CMD_VOUT        8'h8B
`define PMT_CMD_IOUT        8'h8C
`define PMT_CMD_TEMP2       8'h8E
`define PMT_CMD_FREQ        8'h95
// reset values and pec polynomial
`define PMT_OPER_RST        8'h00
`define PMT_ONOFF_RST       8'h16
`define PMT_MASK_RST        8'h00
`define PMT_VOUT_MODE_RST   8'h00
`define PMT_PEC_POLY        8'h07
// field positions
`define PMT_OPER_ON         7
`define PMT_ONOFF_PU        4
`define PMT_ONOFF_CMD       3
`define PMT_ONOFF_CP        2
`define PMT_ONOFF_POL       1
`define PMT_ST_CML          7
`define PMT_IOUT_FSH        3
`endif

// file: logic/pmt_pkg.sv
`include "pmt_cfg.svh"
package pmt_pkg;
   typedef enum logic [2:0] {
      PMT_T_IDLE = 3'b000,
      PMT_T_ADDR = 3'b001,
      PMT_T_CMD  = 3'b010,
      PMT_T_WDAT = 3'b011,
      PMT_T_RDAT = 3'b100,
      PMT_T_WAIT = 3'b101
   } pmt_tst_t;
   typedef enum logic [2:0] {
      PMT_H_IDLE  = 3'b000,
      PMT_H_START = 3'b001,
      PMT_H_LOW   = 3'b010,
      PMT_H_HIGH  = 3'b011,
      PMT_H_RS    = 3'b100,
      PMT_H_STOP  = 3'b101
   } pmt_hst_t;
   typedef struct packed {
      logic [2:0]           scl_sy;
      logic [2:0]           sda_sy;
      logic [1:0]           ctl_sy;
      pmt_tst_t             st;
      logic [3:0]           bitc;
      logic [1:0]           nb;
      logic                 tx;
      logic                 nack;
      logic                 addr_ok;
      logic [6:0]           addr;
      logic [7:0]           sh, txb, cmd, d0, last, crc, crcp;
      logic [7:0]           oper, onoff, mask, status;
      logic [7:0]           str_cnt;
      logic [`PMT_TMR_W-1:0] str_tot, tmo;
      logic [13:0]          iacc;
      logic                 scl_oe_n, sda_oe_n, alert_oe_n, conv_en, fault_off;
   } pmt_tgt_s_t;
   typedef struct packed {
      logic [1:0]  scl_sy;
      logic [1:0]  sda_sy;
      pmt_hst_t    st;
      logic [8:0]  ph;
      logic [3:0]  bitc;
      logic [2:0]  idx;
      logic        rd, pec;
      logic [1:0]  len;
      logic [6:0]  addr;
      logic [7:0]  cmd, rxb, crc;
      logic [15:0] wd, rdata;
      logic        scl_oe_n, sda_oe_n, busy, done, nack, pec_err;
   } pmt_hst_s_t;
   // crc-8 over one byte
   function automatic logic [7:0] pmt_crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ((x << 1) ^ `PMT_PEC_POLY) : (x << 1);
      end
      return x;
   endfunction : pmt_crc8
endpackage : pmt_pkg

// file: logic/pmt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pmt_if;
   // host drives
   logic h_scl_o, h_scl_oe_n, h_sda_o, h_sda_oe_n;
   // target drives
   logic t_scl_o, t_scl_oe_n, t_sda_o, t_sda_oe_n, t_alert_o, t_alert_oe_n;
   // resolved open-drain lines with pull-ups
   logic scl, sda, alert;
   assign scl   = ~((~h_scl_oe_n & ~h_scl_o) | (~t_scl_oe_n & ~t_scl_o));
   assign sda   = ~((~h_sda_oe_n & ~h_sda_o) | (~t_sda_oe_n & ~t_sda_o));
   assign alert = ~(~t_alert_oe_n & ~t_alert_o);
   modport tgt  (input scl, sda, output t_scl_o, t_scl_oe_n, t_sda_o, t_sda_oe_n,
                 t_alert_o, t_alert_oe_n);
   modport host (input scl, sda, alert, output h_scl_o, h_scl_oe_n, h_sda_o, h_sda_oe_n);
endinterface : pmt_if
`default_nettype wire

// file: logic/pmt_target.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"
module pmt_target #(
   parameter int STRETCH_LIM_CYC = `PMT_STRETCH_MS * (`PMT_CLK_HZ / 1000),
   parameter int TIMEOUT_CYC     = `PMT_TIMEOUT_MS * (`PMT_CLK_HZ / 1000),
   parameter logic [7:0] VOUT_MODE = `PMT_VOUT_MODE_RST
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // bus side
   pmt_if.tgt               bus,
   // strap and enable pins
   input  wire logic [6:0]  addr_sel,
   input  wire logic        ctrl_pin,
   // telemetry from the converter
   input  wire logic [15:0] vin_lin,
   input  wire logic [15:0] vout_lin,
   input  wire logic [15:0] temp_lin,
   input  wire logic [15:0] freq_lin,
   input  wire logic        iout_vld,
   input  wire logic [10:0] iout_mant,
   input  wire logic [4:0]  iout_exp,
   // monitor conditions
   input  wire logic [3:0]  fault_in,
   input  wire logic [2:0]  warn_in,
   // converter control
   output logic             conv_en,
   output logic             fault_off,
   output logic [7:0]       status
);
   import pmt_pkg::*;

   localparam logic [`PMT_TMR_W-1:0] LIM_L = `PMT_TMR_W'(STRETCH_LIM_CYC);
   localparam logic [`PMT_TMR_W-1:0] TMO_L = `PMT_TMR_W'(TIMEOUT_CYC - 1);

   pmt_tgt_s_t s_r, s_nxt;
   logic       scl_r, scl_f, sda_r, sda_f, start, stop, clr, cml, ctl_on, on;
   logic [7:0] b;
   logic [1:0] wlen, rlen;
   logic [15:0] rword;

   ////////////////////////////////////////////////////////////////////////
   // read data selection by command
   always_comb begin
      rlen  = 2'd2;
      rword = 16'h0000;
      case (s_r.cmd)
         `PMT_CMD_OPER:      begin rlen = 2'd1; rword = {8'h00, s_r.oper};  end
         `PMT_CMD_ONOFF:     begin rlen = 2'd1; rword = {8'h00, s_r.onoff}; end
         `PMT_CMD_MASK:      begin rlen = 2'd1; rword = {8'h00, s_r.mask};  end
         `PMT_CMD_STATUS:    begin rlen = 2'd1; rword = {8'h00, s_r.status}; end
         `PMT_CMD_VOUT_MODE: begin rlen = 2'd1; rword = {8'h00, VOUT_MODE}; end
         `PMT_CMD_VIN:       rword = vin_lin;
         `PMT_CMD_VOUT:      rword = vout_lin;
         `PMT_CMD_IOUT:      rword = {iout_exp, s_r.iacc[`PMT_IOUT_FSH +: 11]};
         `PMT_CMD_TEMP2:     rword = temp_lin;
         `PMT_CMD_FREQ:      rword = freq_lin;
         default:            rlen = 2'd0;
      endcase
   end

   // write length by command, 3 marks unknown
   always_comb begin
      case (s_r.cmd)
         `PMT_CMD_CLEAR: wlen = 2'd0;
         `PMT_CMD_OPER:  wlen = 2'd1;
         `PMT_CMD_ONOFF: wlen = 2'd1;
         `PMT_CMD_MASK:  wlen = 2'd1;
         default:        wlen = 2'd3;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt  = s_r;
      clr    = 1'b0;
      cml    = 1'b0;
      b      = s_r.sh;
      s_nxt.scl_sy = {s_r.scl_sy[1:0], bus.scl};
      s_nxt.sda_sy = {s_r.sda_sy[1:0], bus.sda};
      s_nxt.ctl_sy = {s_r.ctl_sy[0], ctrl_pin};
      scl_r = s_r.scl_sy[1] & ~s_r.scl_sy[2];
      scl_f = ~s_r.scl_sy[1] & s_r.scl_sy[2];
      sda_r = s_r.sda_sy[1] & ~s_r.sda_sy[2];
      sda_f = ~s_r.sda_sy[1] & s_r.sda_sy[2];
      start = s_r.scl_sy[1] & s_r.scl_sy[2] & sda_f;
      stop  = s_r.scl_sy[1] & s_r.scl_sy[2] & sda_r;
      if (!s_r.addr_ok) begin
         s_nxt.addr    = addr_sel;
         s_nxt.addr_ok = 1'b1;
      end
      if (iout_vld) begin
         s_nxt.iacc = s_r.iacc + 14'(signed'(iout_mant))
                      - 14'($signed(s_r.iacc) >>> `PMT_IOUT_FSH);
      end
      // stretch countdown
      if (s_r.str_cnt != 8'h00) begin
         s_nxt.str_cnt = s_r.str_cnt - 8'h01;
         s_nxt.str_tot = s_r.str_tot + `PMT_TMR_W'(1);
      end
      if (start) begin
         if (s_r.st == PMT_T_IDLE || s_r.st == PMT_T_WAIT) s_nxt.crc = 8'h00;
         if (s_r.st == PMT_T_IDLE || s_r.st == PMT_T_WAIT) s_nxt.str_tot = '0;
         s_nxt.st       = PMT_T_ADDR;
         s_nxt.bitc     = 4'd0;
         s_nxt.tx       = 1'b0;
         s_nxt.sda_oe_n = 1'b1;
      end else if (stop) begin
         if (s_r.st == PMT_T_WDAT) begin
            if (wlen != 2'd3 && (s_r.nb == wlen
                || (s_r.nb == wlen + 2'd1 && s_r.last == s_r.crcp))) begin
               case (s_r.cmd)
                  `PMT_CMD_OPER:  s_nxt.oper  = s_r.d0;
                  `PMT_CMD_ONOFF: s_nxt.onoff = s_r.d0;
                  `PMT_CMD_MASK:  s_nxt.mask  = s_r.d0;
                  default:        clr = 1'b1;
               endcase
            end else begin
               cml = 1'b1;
            end
         end
         s_nxt.st       = PMT_T_IDLE;
         s_nxt.sda_oe_n = 1'b1;
      end else if (s_r.st != PMT_T_IDLE && s_r.st != PMT_T_WAIT) begin
         if (scl_r) begin
            if (s_r.bitc < 4'd8) begin
               s_nxt.sh   = {s_r.sh[6:0], s_r.sda_sy[1]};
               s_nxt.bitc = s_r.bitc + 4'd1;
            end else begin
               s_nxt.bitc = 4'd9;
               if (s_r.tx) s_nxt.nack = s_r.sda_sy[1];
            end
         end else if (scl_f) begin
            if (s_r.bitc == 4'd8 && s_r.tx) begin
               s_nxt.sda_oe_n = 1'b1;
            end else if (s_r.bitc == 4'd8) begin
               s_nxt.sda_oe_n = 1'b0;
               s_nxt.crc      = pmt_crc8(s_r.crc, b);
               if (s_r.str_tot < LIM_L) s_nxt.str_cnt = `PMT_STRETCH_CYC;
               case (s_r.st)
                  PMT_T_ADDR: begin
                     if (b[7:1] != s_r.addr) begin
                        s_nxt.sda_oe_n = 1'b1;
                        s_nxt.str_cnt  = 8'h00;
                        s_nxt.st       = PMT_T_WAIT;
                     end else if (b[0]) begin
                        s_nxt.st = PMT_T_RDAT;
                        s_nxt.nb = 2'd0;
                     end else begin
                        s_nxt.st = PMT_T_CMD;
                     end
                  end
                  PMT_T_CMD: begin
                     s_nxt.cmd = b;
                     s_nxt.nb  = 2'd0;
                     s_nxt.st  = PMT_T_WDAT;
                  end
                  default: begin
                     s_nxt.crcp = s_r.crc;
                     s_nxt.last = b;
                     if (s_r.nb == 2'd0) s_nxt.d0 = b;
                     if (s_r.nb != 2'd3) s_nxt.nb = s_r.nb + 2'd1;
                  end
               endcase
            end else if (s_r.bitc == 4'd9) begin
               s_nxt.bitc     = 4'd0;
               s_nxt.sda_oe_n = 1'b1;
               if (s_r.st == PMT_T_RDAT) begin
                  if (s_r.tx && s_r.nack) begin
                     s_nxt.st = PMT_T_WAIT;
                  end else begin
                     s_nxt.tx  = 1'b1;
                     s_nxt.txb = (s_r.nb < rlen) ? rword[s_r.nb[0]*8 +: 8]
                               : (s_r.nb == rlen) ? s_r.crc : 8'hFF;
                     s_nxt.crc = pmt_crc8(s_r.crc, s_nxt.txb);
                     s_nxt.sda_oe_n = s_nxt.txb[7];
                     if (s_r.nb != 2'd3) s_nxt.nb = s_r.nb + 2'd1;
                  end
               end
            end else if (s_r.tx && s_r.bitc < 4'd8) begin
               s_nxt.sda_oe_n = s_r.txb[3'd7 - s_r.bitc[2:0]];
            end
         end
      end
      if (s_r.st != PMT_T_IDLE && !s_r.scl_sy[1]) begin
         s_nxt.tmo = s_r.tmo + `PMT_TMR_W'(1);
      end else begin
         s_nxt.tmo = '0;
      end
      if (s_r.tmo == TMO_L) begin
         s_nxt.st       = PMT_T_IDLE;
         s_nxt.sda_oe_n = 1'b1;
         s_nxt.str_cnt  = 8'h00;
         s_nxt.tmo      = '0;
      end
      if (s_nxt.str_tot >= LIM_L) s_nxt.str_cnt = 8'h00;
      s_nxt.scl_oe_n = (s_nxt.str_cnt == 8'h00);
      s_nxt.status = (clr ? 8'h00 : s_r.status) | {cml, warn_in, fault_in};
      s_nxt.alert_oe_n = ~|(s_nxt.status & ~s_nxt.mask);
      s_nxt.fault_off = |s_nxt.status[3:0];
      ctl_on = s_nxt.onoff[`PMT_ONOFF_POL] ? s_r.ctl_sy[1] : ~s_r.ctl_sy[1];
      on = ~s_nxt.onoff[`PMT_ONOFF_PU]
         | ((~s_nxt.onoff[`PMT_ONOFF_CMD] | s_nxt.oper[`PMT_OPER_ON])
            & (~s_nxt.onoff[`PMT_ONOFF_CP] | ctl_on));
      s_nxt.conv_en = on & ~s_nxt.fault_off;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r            <= '0;
         s_r.scl_sy     <= 3'b111;
         s_r.sda_sy     <= 3'b111;
         s_r.st         <= PMT_T_IDLE;
         s_r.oper       <= `PMT_OPER_RST;
         s_r.onoff      <= `PMT_ONOFF_RST;
         s_r.mask       <= `PMT_MASK_RST;
         s_r.scl_oe_n   <= 1'b1;
         s_r.sda_oe_n   <= 1'b1;
         s_r.alert_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs from flops
   assign bus.t_scl_o      = 1'b0;
   assign bus.t_sda_o      = 1'b0;
   assign bus.t_alert_o    = 1'b0;
   assign bus.t_scl_oe_n   = s_r.scl_oe_n;
   assign bus.t_sda_oe_n   = s_r.sda_oe_n;
   assign bus.t_alert_oe_n = s_r.alert_oe_n;
   assign conv_en          = s_r.conv_en;
   assign fault_off        = s_r.fault_off;
   assign status           = s_r.status;
endmodule : pmt_target
`default_nettype wire

// file: logic/pmt_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"
module pmt_host (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // bus side
   pmt_if.host              bus,
   // request
   input  wire logic        req,
   input  wire logic        rd,
   input  wire logic [6:0]  addr,
   input  wire logic [7:0]  cmd,
   input  wire logic [15:0] wdata,
   input  wire logic [1:0]  len,
   input  wire logic        pec_en,
   // answer
   output logic             busy,
   output logic             done,
   output logic [15:0]      rdata,
   output logic             nack,
   output logic             pec_err
);
   import pmt_pkg::*;

   localparam logic [8:0] HALF = 9'(`PMT_CLK_HZ / `PMT_SCL_HZ / 2);
   localparam logic [8:0] QTR  = HALF >> 1;
   localparam int SU_CYC = (`PMT_SU_DAT_NS * (`PMT_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [8:0] SU_L = 9'(SU_CYC);
   localparam logic [8:0] DRV  = (HALF - QTR > SU_L) ? QTR : 9'd1;

   pmt_hst_s_t s_r, s_nxt;
   logic [2:0] last_idx;
   logic       rxm, lastb;
   logic [7:0] txb;

   ////////////////////////////////////////////////////////////////////////
   // byte sequence of the transfer
   always_comb begin
      last_idx = s_r.rd ? 3'(3'd2 + s_r.len + s_r.pec) : 3'(3'd1 + s_r.len + s_r.pec);
      rxm      = s_r.rd && s_r.idx >= 3'd3;
      lastb    = s_r.idx == last_idx;
      case (s_r.idx)
         3'd0:    txb = {s_r.addr, 1'b0};
         3'd1:    txb = s_r.cmd;
         3'd2:    txb = s_r.rd ? {s_r.addr, 1'b1} : (s_r.len == 2'd0 ? s_r.crc : s_r.wd[7:0]);
         default: txb = (s_r.len == 2'd2) ? s_r.wd[15:8] : s_r.crc;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt        = s_r;
      s_nxt.done   = 1'b0;
      s_nxt.scl_sy = {s_r.scl_sy[0], bus.scl};
      s_nxt.sda_sy = {s_r.sda_sy[0], bus.sda};
      s_nxt.ph     = s_r.ph + 9'd1;
      case (s_r.st)
         PMT_H_IDLE: begin
            s_nxt.ph = 9'd0;
            if (req) begin
               s_nxt = '{default: '0, st: PMT_H_START, busy: 1'b1, rd: rd, pec: pec_en,
                         len: len, addr: addr, cmd: cmd, wd: wdata, scl_oe_n: 1'b1,
                         sda_oe_n: 1'b0, scl_sy: s_nxt.scl_sy, sda_sy: s_nxt.sda_sy};
            end
         end
         PMT_H_START: begin
            if (s_r.ph == HALF) begin
               s_nxt.scl_oe_n = 1'b0;
               s_nxt.st       = PMT_H_LOW;
               s_nxt.ph       = 9'd0;
            end
         end
         PMT_H_LOW: begin
            if (s_r.ph == DRV) begin
               if (s_r.bitc < 4'd8) s_nxt.sda_oe_n = rxm | txb[3'd7 - s_r.bitc[2:0]];
               else                 s_nxt.sda_oe_n = ~rxm | (lastb & s_r.pec) | lastb;
            end
            if (s_r.ph >= HALF) begin
               s_nxt.scl_oe_n = 1'b1;
               s_nxt.ph       = HALF;
               if (s_r.scl_sy[1]) begin
                  s_nxt.st = PMT_H_HIGH;
                  s_nxt.ph = 9'd0;
               end
            end
         end
         PMT_H_HIGH: begin
            if (s_r.ph == QTR && s_r.bitc < 4'd8) s_nxt.rxb = {s_r.rxb[6:0], s_r.sda_sy[1]};
            if (s_r.ph == QTR && s_r.bitc == 4'd8 && !rxm && s_r.sda_sy[1]) s_nxt.nack = 1'b1;
            if (s_r.ph == HALF) begin
               s_nxt.scl_oe_n = 1'b0;
               s_nxt.ph       = 9'd0;
               s_nxt.st       = PMT_H_LOW;
               s_nxt.bitc     = s_r.bitc + 4'd1;
               if (s_r.bitc == 4'd8) begin
                  s_nxt.bitc = 4'd0;
                  s_nxt.idx  = s_r.idx + 3'd1;
                  s_nxt.crc  = pmt_crc8(s_r.crc, rxm ? s_r.rxb : txb);
                  if (rxm && s_r.pec && lastb) s_nxt.pec_err = (s_r.rxb != s_r.crc);
                  if (rxm && s_r.idx == 3'd3) s_nxt.rdata[7:0] = s_r.rxb;
                  if (rxm && s_r.idx == 3'd4 && s_r.len == 2'd2) s_nxt.rdata[15:8] = s_r.rxb;
                  if (lastb || s_nxt.nack) s_nxt.st = PMT_H_STOP;
                  else if (s_r.rd && s_r.idx == 3'd1) s_nxt.st = PMT_H_RS;
               end
            end
         end
         PMT_H_RS: begin
            if (s_r.ph == DRV) s_nxt.sda_oe_n = 1'b1;
            if (s_r.ph >= HALF && !s_r.scl_oe_n) s_nxt.scl_oe_n = 1'b1;
            if (s_r.ph >= HALF && !s_r.scl_sy[1]) s_nxt.ph = HALF;
            // ph is too narrow for three halves, bitc marks the second high half
            if (s_r.ph == HALF + HALF && s_r.bitc == 4'd0) begin
               s_nxt.sda_oe_n = 1'b0;
               s_nxt.ph       = HALF;
               s_nxt.bitc     = 4'd1;
            end
            if (s_r.ph == HALF + HALF && s_r.bitc != 4'd0) begin
               s_nxt.scl_oe_n = 1'b0;
               s_nxt.ph       = 9'd0;
               s_nxt.bitc     = 4'd0;
               s_nxt.st       = PMT_H_LOW;
            end
         end
         PMT_H_STOP: begin
            if (s_r.ph == DRV) s_nxt.sda_oe_n = 1'b0;
            if (s_r.ph >= HALF && !s_r.scl_oe_n) s_nxt.scl_oe_n = 1'b1;
            if (s_r.ph >= HALF && !s_r.scl_sy[1]) s_nxt.ph = HALF;
            // stop edge, then one more half before the bus counts as free
            if (s_r.ph == HALF + HALF && s_r.bitc == 4'd0) begin
               s_nxt.sda_oe_n = 1'b1;
               s_nxt.ph       = HALF;
               s_nxt.bitc     = 4'd1;
            end
            if (s_r.ph == HALF + HALF && s_r.bitc != 4'd0) begin
               s_nxt.st   = PMT_H_IDLE;
               s_nxt.busy = 1'b0;
               s_nxt.done = 1'b1;
            end
         end
         default: s_nxt.st = PMT_H_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r          <= '0;
         s_r.scl_sy   <= 2'b11;
         s_r.sda_sy   <= 2'b11;
         s_r.st       <= PMT_H_IDLE;
         s_r.scl_oe_n <= 1'b1;
         s_r.sda_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs from flops
   assign bus.h_scl_o    = 1'b0;
   assign bus.h_sda_o    = 1'b0;
   assign bus.h_scl_oe_n = s_r.scl_oe_n;
   assign bus.h_sda_oe_n = s_r.sda_oe_n;
   assign busy           = s_r.busy;
   assign done           = s_r.done;
   assign rdata          = s_r.rdata;
   assign nack           = s_r.nack;
   assign pec_err        = s_r.pec_err;
endmodule : pmt_host
`default_nettype wire

// file: verif/pmt_chk_props.sv
`timescale 1ns/1ps
`default_nettype none
module pmt_chk #(
   parameter int STRETCH_LIM_CYC = 64,
   parameter int TIMEOUT_CYC     = 2000
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus lines and drivers
   input wire logic scl,
   input wire logic sda,
   input wire logic h_scl_oe_n,
   input wire logic t_scl_oe_n,
   input wire logic t_sda_oe_n
);
   logic ps, pd, hp;
   int   stc, loc, hc;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // past lines, stretch total, low run, host phase length
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {ps, pd, hp} <= 3'h7;
         {stc, loc, hc} <= '0;
      end else begin
         ps  <= scl;
         pd  <= sda;
         hp  <= h_scl_oe_n;
         stc <= (ps && scl && pd && !sda) ? 0 : stc + (t_scl_oe_n ? 0 : 1);
         loc <= scl ? 0 : loc + 1;
         hc  <= (h_scl_oe_n != hp) ? 1 : hc + 1;
      end
   end
   property p_str_len; $fell(t_scl_oe_n) |-> !t_scl_oe_n [*8] ##[8:9] t_scl_oe_n; endproperty
   a_str_len: assert property (p_str_len) else $error("stretch length");
   property p_str_low; $fell(t_scl_oe_n) |-> !ps && !scl; endproperty
   a_str_low: assert property (p_str_low) else $error("stretch on high clock");
   property p_str_ack; $fell(t_scl_oe_n) |-> !t_sda_oe_n; endproperty
   a_str_ack: assert property (p_str_ack) else $error("stretch without ack");
   property p_cum; stc <= STRETCH_LIM_CYC; endproperty
   a_cum: assert property (p_cum) else $error("stretch total too long");
   property p_tmo; loc == TIMEOUT_CYC |-> ##[1:8] (t_scl_oe_n && t_sda_oe_n); endproperty
   a_tmo: assert property (p_tmo) else $error("timeout not abandoned");
   property p_sda_hold; ps && scl |-> $stable(t_sda_oe_n); endproperty
   a_sda_hold: assert property (p_sda_hold) else $error("data moved in high clock");
   property p_rate; h_scl_oe_n != hp |-> hc >= 199; endproperty
   a_rate: assert property (p_rate) else $error("clock phase too short");
   property p_stop_rel; ps && scl && !pd && sda |-> (t_sda_oe_n && t_scl_oe_n) [*8]; endproperty
   a_stop_rel: assert property (p_stop_rel) else $error("lines held after stop");
endmodule : pmt_chk
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmt_cfg.svh"
module tb_top;
   import pmt_pkg::*;
   localparam logic [6:0] ADR = 7'h2A;
   logic        clk = 0, rst_n = 0, req = 0, rd = 0, pec_en = 0, ctrl_pin = 0, iv = 0;
   logic [1:0]  len = 2'h0;
   logic [2:0]  warn_in = 3'h0;
   logic [3:0]  fault_in = 4'h0;
   logic [6:0]  addr = ADR;
   logic [7:0]  cmd = 8'h00, status;
   logic [10:0] mant = 11'h000;
   logic [15:0] wdata = 16'h0000, rdata, tv = 16'hD2A5;
   logic        conv_en, fault_off, busy, done, nack, pec_err;
   int          error_cnt = 0, check_count = 0;
   // the two ends on one bus
   pmt_if pmt_if_inst ();
   pmt_target #(.STRETCH_LIM_CYC(48), .TIMEOUT_CYC(2000)) pmt_target_inst (
      .clk(clk), .rst_n(rst_n), .bus(pmt_if_inst), .addr_sel(ADR), .ctrl_pin(ctrl_pin),
      .vin_lin(tv), .vout_lin(~tv), .temp_lin(~tv), .freq_lin(~tv), .iout_vld(iv),
      .iout_mant(mant), .iout_exp(tv[15:11]), .fault_in(fault_in), .warn_in(warn_in),
      .conv_en(conv_en), .fault_off(fault_off), .status(status));
   pmt_host pmt_host_inst (
      .clk(clk), .rst_n(rst_n), .bus(pmt_if_inst), .req(req), .rd(rd), .addr(addr),
      .cmd(cmd), .wdata(wdata), .len(len), .pec_en(pec_en), .busy(busy), .done(done),
      .rdata(rdata), .nack(nack), .pec_err(pec_err));
   pmt_chk #(.STRETCH_LIM_CYC(48), .TIMEOUT_CYC(2000)) pmt_chk_inst (
      .clk(clk), .rst_n(rst_n), .scl(pmt_if_inst.scl), .sda(pmt_if_inst.sda),
      .h_scl_oe_n(pmt_if_inst.h_scl_oe_n), .t_scl_oe_n(pmt_if_inst.t_scl_oe_n),
      .t_sda_oe_n(pmt_if_inst.t_sda_oe_n));
   // clock
   initial forever #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (error_cnt == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // one host transfer, waits for done
   task automatic xfer(input logic r, input logic [7:0] c, input logic [15:0] w,
                       input logic [1:0] l, input logic p);
      int n;
      n = 0;
      @(posedge clk);
      {rd, cmd, wdata, len, pec_en, req} <= {r, c, w, l, p, 1'h1};
      @(posedge clk);
      req <= 1'h0;
      @(negedge clk);
      chk("busy", 16'h0001, busy);
      while (done !== 1'h1 && n < 40000) begin
         @(negedge clk);
         n++;
      end
      chk("done", 16'h0001, done);
   endtask : xfer
   task automatic settle();
      repeat (10) @(negedge clk);
   endtask : settle
   ////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      #2500us;
      error_cnt++;
      report_and_stop();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      ctrl_pin <= 1'h1;
      settle();
      chk("conv_en", 16'h0001, conv_en);
      chk("alert", 16'h0001, pmt_if_inst.alert);
      @(posedge clk) ctrl_pin <= 1'h0;
      settle();
      chk("conv_en", 16'h0000, conv_en);
      @(posedge clk) {iv, mant} <= {1'h1, 11'h040};
      @(posedge clk) iv <= 1'h0;
      xfer(1'h1, `PMT_CMD_IOUT, 16'h0000, 2'h2, 1'h0);
      chk("iout", {tv[15:11], 11'h008}, rdata);
      xfer(1'h1, `PMT_CMD_VIN, 16'h0000, 2'h2, 1'h1);
      chk("vin", tv, rdata);
      chk("pec_err", 16'h0000, pec_err);
      @(posedge clk) ctrl_pin <= 1'h1;
      xfer(1'h0, `PMT_CMD_ONOFF, 16'h001A, 2'h1, 1'h0);
      settle();
      chk("conv_en", 16'h0000, conv_en);
      xfer(1'h0, `PMT_CMD_OPER, 16'h0080, 2'h1, 1'h1);
      settle();
      chk("conv_en", 16'h0001, conv_en);
      @(posedge clk) addr <= ADR + 7'h01;
      xfer(1'h0, `PMT_CMD_CLEAR, 16'h0000, 2'h0, 1'h0);
      chk("nack", 16'h0001, nack);
      @(posedge clk) warn_in <= 3'h1;
      settle();
      chk("status", 16'h0010, status);
      chk("alert", 16'h0000, pmt_if_inst.alert);
      chk("fault_off", 16'h0000, fault_off);
      @(posedge clk) fault_in <= 4'h1;
      settle();
      chk("fault_off", 16'h0001, fault_off);
      chk("conv_en", 16'h0000, conv_en);
      @(posedge clk) addr <= ADR;
      xfer(1'h0, `PMT_CMD_MASK, 16'h0011, 2'h1, 1'h0);
      settle();
      chk("alert", 16'h0001, pmt_if_inst.alert);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
